// ---- hdl/tbdc_params.svh ----
// Shared constants for the total, batch and dual counting block
`ifndef TBDC_PARAMS_SVH
`define TBDC_PARAMS_SVH
`define TBDC_CNT_W 20
`define TBDC_DUAL_W 21
`define TBDC_FULL_SCALE 20'hf423f
`define TBDC_ZERO 20'h00000
`define TBDC_ONE 20'h00001
`define TBDC_PIN_N 5
`define TBDC_PIN_CNT_A 0
`define TBDC_PIN_CNT_B 1
`define TBDC_PIN_RST_A 2
`define TBDC_PIN_RST_B 3
`define TBDC_PIN_KEY 4
`endif

// ---- hdl/tbdc_pkg.sv ----
// Types for the total, batch and dual counting block
`default_nettype none
package tbdc_pkg;
	typedef enum logic [1:0] {MODE_TOTAL, MODE_BATCH, MODE_DUAL} tbdc_mode_t;
	typedef enum logic [2:0] {VIEW_PRESENT, VIEW_TOTAL, VIEW_BATCH, VIEW_DUAL, VIEW_CHAN} tbdc_view_t;
	typedef enum logic {PH_RESTORE, PH_RUN} tbdc_phase_t;
endpackage
`default_nettype wire

// ---- hdl/tbdc_if.sv ----
// Carriers between the pin conditioner, the dual adder and the core
`timescale 1ns/1ps
`default_nettype none
`include "tbdc_params.svh"
interface tbdc_pin_if;
	logic countPulseA, countPulseB, resetLvlA, resetLvlB, keyPulse, keyLvl;
	modport src (output countPulseA, countPulseB, resetLvlA, resetLvlB, keyPulse, keyLvl);
	modport dst (input countPulseA, countPulseB, resetLvlA, resetLvlB, keyPulse, keyLvl);
endinterface

interface tbdc_dual_if;
	logic [`TBDC_CNT_W-1:0] chanA, chanB;
	logic zeroA, zeroB, subtract, match;
	logic signed [`TBDC_DUAL_W-1:0] setValue, dualValue;
	modport calc (input chanA, chanB, zeroA, zeroB, subtract, setValue, output dualValue, match);
	modport core (output chanA, chanB, zeroA, zeroB, subtract, setValue, input dualValue, match);
endinterface
`default_nettype wire

// ---- hdl/tbdc_pin_sync.sv ----
// Three-stage pin conditioner with agreement filter and rising-edge pulses
`timescale 1ns/1ps
`default_nettype none
`include "tbdc_params.svh"
module tbdc_pin_sync (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [`TBDC_PIN_N-1:0] pins,
	tbdc_pin_if.src pinBus
);
	typedef struct packed {
		logic [`TBDC_PIN_N-1:0] s1, s2, s3, stable, rise;
	} tbdc_sync_st_t;
	tbdc_sync_st_t st, next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = pins;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// A level is accepted only once the last two stages agree
		next_st.stable = (st.s2 & st.s3) | (st.stable & (st.s2 | st.s3));
		next_st.rise = next_st.stable & ~st.stable;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pinBus.countPulseA = st.rise[`TBDC_PIN_CNT_A];
	assign pinBus.countPulseB = st.rise[`TBDC_PIN_CNT_B];
	assign pinBus.resetLvlA = st.stable[`TBDC_PIN_RST_A];
	assign pinBus.resetLvlB = st.stable[`TBDC_PIN_RST_B];
	assign pinBus.keyPulse = st.rise[`TBDC_PIN_KEY];
	assign pinBus.keyLvl = st.stable[`TBDC_PIN_KEY];

	sequence s_riseA;
		!st.stable[`TBDC_PIN_CNT_A] ##1 st.stable[`TBDC_PIN_CNT_A];
	endsequence
	sequence s_heldA;
		(!st.s2[`TBDC_PIN_CNT_A] && !st.s3[`TBDC_PIN_CNT_A] && !st.stable[`TBDC_PIN_CNT_A] && pins[`TBDC_PIN_CNT_A])
			##1 pins[`TBDC_PIN_CNT_A] [*3];
	endsequence
	chk_pulse_single: assert property (@(posedge clk) disable iff (!resetn)
		s_riseA |-> pinBus.countPulseA ##1 !pinBus.countPulseA) else $error("Count pulse not single");
	chk_pulse_held: assert property (@(posedge clk) disable iff (!resetn)
		s_heldA |-> ##[0:1] pinBus.countPulseA) else $error("Held count input gave no pulse");
endmodule
`default_nettype wire

// ---- hdl/tbdc_dual_calc.sv ----
// Registered sum or difference of the two channel values with match compare
`timescale 1ns/1ps
`default_nettype none
`include "tbdc_params.svh"
module tbdc_dual_calc (
	input wire logic clk,
	input wire logic resetn,
	tbdc_dual_if.calc dualBus
);
	typedef struct packed {
		logic signed [`TBDC_DUAL_W-1:0] dual;
		logic match;
	} tbdc_dual_st_t;
	tbdc_dual_st_t st, next_st;

	always_comb begin
		logic signed [`TBDC_DUAL_W-1:0] opA;
		logic signed [`TBDC_DUAL_W-1:0] opB;
		opA = dualBus.zeroA ? '0 : $signed({1'b0, dualBus.chanA});
		opB = dualBus.zeroB ? '0 : $signed({1'b0, dualBus.chanB});
		next_st = st;
		next_st.dual = dualBus.subtract ? opA - opB : opA + opB;
		next_st.match = next_st.dual == dualBus.setValue;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign dualBus.dualValue = st.dual;
	assign dualBus.match = st.match;

	chk_dual_add: assert property (@(posedge clk) disable iff (!resetn)
		!dualBus.zeroA && !dualBus.zeroB && !dualBus.subtract |=>
		dualBus.dualValue == $signed({1'b0, $past(dualBus.chanA)}) + $signed({1'b0, $past(dualBus.chanB)}))
		else $error("Dual sum wrong");
	chk_dual_sub: assert property (@(posedge clk) disable iff (!resetn)
		!dualBus.zeroA && !dualBus.zeroB && dualBus.subtract |=>
		dualBus.dualValue == $signed({1'b0, $past(dualBus.chanA)}) - $signed({1'b0, $past(dualBus.chanB)}))
		else $error("Dual difference wrong");
	chk_dual_zero: assert property (@(posedge clk) disable iff (!resetn)
		dualBus.zeroA && !dualBus.zeroB |=> dualBus.dualValue == ($past(dualBus.subtract) ?
		-$signed({1'b0, $past(dualBus.chanB)}) : $signed({1'b0, $past(dualBus.chanB)})))
		else $error("Held channel not zero");
endmodule
`default_nettype wire

// ---- hdl/tbdc_counter_core.sv ----
// Total, batch and dual counting core of the multifunction preset counter
`timescale 1ns/1ps
`default_nettype none
`include "tbdc_params.svh"
module tbdc_counter_core (
	input wire logic clk,
	input wire logic resetn,
	input wire logic countInputA,
	input wire logic countInputB,
	input wire logic resetInputA,
	input wire logic resetInputB,
	input wire logic resetKey,
	input wire tbdc_pkg::tbdc_mode_t modeSel,
	input wire tbdc_pkg::tbdc_view_t viewSel,
	input wire logic outputHold,
	input wire logic calcSubtract,
	input wire logic [`TBDC_CNT_W-1:0] presetValue,
	input wire logic [`TBDC_CNT_W-1:0] batchSetValue,
	input wire logic signed [`TBDC_DUAL_W-1:0] dualSetValue,
	input wire logic restoredBatchOut,
	output logic [`TBDC_CNT_W-1:0] presentCount,
	output logic [`TBDC_CNT_W-1:0] totalCount,
	output logic [`TBDC_CNT_W-1:0] batchCount,
	output logic [`TBDC_CNT_W-1:0] chanCountA,
	output logic [`TBDC_CNT_W-1:0] chanCountB,
	output logic signed [`TBDC_DUAL_W-1:0] dualCount,
	output logic overflowFlag,
	output logic batchOutStore,
	output logic firstControlOutput,
	output logic secondControlOutput
);
	typedef struct packed {
		tbdc_pkg::tbdc_phase_t phase;
		logic [`TBDC_CNT_W-1:0] present;
		logic [`TBDC_CNT_W-1:0] total;
		logic [`TBDC_CNT_W-1:0] batch;
		logic [`TBDC_CNT_W-1:0] chanA;
		logic [`TBDC_CNT_W-1:0] chanB;
		logic ctrl;
		logic batchOut;
		logic overflow;
		logic firstOut;
		logic secondOut;
	} tbdc_core_st_t;
	tbdc_core_st_t st, next_st;

	tbdc_pin_if pinBus ();
	tbdc_dual_if dualBus ();

	logic isTotal, isBatch, isDual, running;
	logic complete, countOk, ovA, ovB;

	function automatic logic [`TBDC_CNT_W-1:0] wrapInc(input logic [`TBDC_CNT_W-1:0] v);
		return (v == `TBDC_FULL_SCALE) ? `TBDC_ZERO : v + `TBDC_ONE;
	endfunction

	function automatic logic hitsPreset(input logic [`TBDC_CNT_W-1:0] v, input logic [`TBDC_CNT_W-1:0] preset);
		return preset != `TBDC_ZERO && v == preset;
	endfunction

	tbdc_pin_sync i_tbdc_pin_sync (
		.clk(clk),
		.resetn(resetn),
		.pins({resetKey, resetInputB, resetInputA, countInputB, countInputA}),
		.pinBus(pinBus)
	);

	tbdc_dual_calc i_tbdc_dual_calc (
		.clk(clk),
		.resetn(resetn),
		.dualBus(dualBus)
	);

	assign isTotal = modeSel == tbdc_pkg::MODE_TOTAL;
	assign isBatch = modeSel == tbdc_pkg::MODE_BATCH;
	assign isDual = modeSel == tbdc_pkg::MODE_DUAL;
	assign running = st.phase == tbdc_pkg::PH_RUN;

	assign dualBus.chanA = st.chanA;
	assign dualBus.chanB = st.chanB;
	assign dualBus.zeroA = pinBus.resetLvlA;
	assign dualBus.zeroB = pinBus.resetLvlB;
	assign dualBus.subtract = calcSubtract;
	assign dualBus.setValue = dualSetValue;

	always_comb begin
		next_st = st;
		complete = 1'b0;
		countOk = 1'b0;
		ovA = 1'b0;
		ovB = 1'b0;
		case (st.phase)
			tbdc_pkg::PH_RESTORE: begin
				// Non-volatile copy is reloaded once, before any counting
				next_st.batchOut = restoredBatchOut;
				next_st.phase = tbdc_pkg::PH_RUN;
			end
			tbdc_pkg::PH_RUN: begin
				if (isDual) begin
					// Key held or overflow freezes both channels
					countOk = !pinBus.keyLvl && !st.overflow;
					ovA = countOk && pinBus.countPulseA && !pinBus.resetLvlA && st.chanA == `TBDC_FULL_SCALE;
					ovB = countOk && pinBus.countPulseB && !pinBus.resetLvlB && st.chanB == `TBDC_FULL_SCALE;
					// Overflow is sticky; only the key clears it, a reset pin does not
					if (ovA || ovB) begin
						next_st.overflow = 1'b1;
					end else if (countOk) begin
						if (pinBus.countPulseA && !pinBus.resetLvlA) begin
							next_st.chanA = st.chanA + `TBDC_ONE;
						end
						if (pinBus.countPulseB && !pinBus.resetLvlB) begin
							next_st.chanB = st.chanB + `TBDC_ONE;
						end
					end
					// Match arrives one cycle after the channels, with the dual value
					next_st.ctrl = dualBus.match | (outputHold & st.ctrl);
					if (pinBus.resetLvlA) begin
						next_st.chanA = `TBDC_ZERO;
					end
					if (pinBus.resetLvlB) begin
						next_st.chanB = `TBDC_ZERO;
					end
					if (pinBus.keyPulse) begin
						next_st.chanA = `TBDC_ZERO;
						next_st.chanB = `TBDC_ZERO;
						next_st.ctrl = 1'b0;
						next_st.overflow = 1'b0;
					end
				end else begin
					if (pinBus.countPulseA) begin
						next_st.total = wrapInc(st.total);
						if (!pinBus.resetLvlA) begin
							complete = hitsPreset(wrapInc(st.present), presetValue);
							// Batch mode recycles the present value on completion
							next_st.present = (isBatch && complete) ? `TBDC_ZERO : wrapInc(st.present);
						end
					end
					next_st.ctrl = complete | (outputHold ? st.ctrl : hitsPreset(next_st.present, presetValue));
					if (isBatch && complete) begin
						next_st.batch = wrapInc(st.batch);
					end
					// Level compare, so a lowered set value also fires; only the batch reset or the key with the batch view selected un-fires it
					if (isBatch && batchSetValue != `TBDC_ZERO && next_st.batch >= batchSetValue) begin
						next_st.batchOut = 1'b1;
					end
					if (pinBus.resetLvlA) begin
						next_st.present = `TBDC_ZERO;
						next_st.ctrl = 1'b0;
					end
					if (isTotal && pinBus.resetLvlB) begin
						next_st.total = `TBDC_ZERO;
					end
					if (isBatch && pinBus.resetLvlB) begin
						next_st.batch = `TBDC_ZERO;
						next_st.batchOut = 1'b0;
					end
					if (pinBus.keyPulse) begin
						next_st.present = `TBDC_ZERO;
						next_st.ctrl = 1'b0;
						if (isTotal && viewSel == tbdc_pkg::VIEW_TOTAL) begin
							next_st.total = `TBDC_ZERO;
						end
						if (isBatch && viewSel == tbdc_pkg::VIEW_BATCH) begin
							next_st.batch = `TBDC_ZERO;
							next_st.batchOut = 1'b0;
						end
					end
				end
			end
			default: begin
				next_st.phase = tbdc_pkg::PH_RESTORE;
			end
		endcase
		next_st.firstOut = isBatch ? next_st.batchOut : next_st.ctrl;
		next_st.secondOut = next_st.ctrl;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign presentCount = st.present;
	assign totalCount = st.total;
	assign batchCount = st.batch;
	assign chanCountA = st.chanA;
	assign chanCountB = st.chanB;
	assign dualCount = dualBus.dualValue;
	assign overflowFlag = st.overflow;
	assign batchOutStore = st.batchOut;
	assign firstControlOutput = st.firstOut;
	assign secondControlOutput = st.secondOut;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence s_setLowered;
		isBatch && running && batchSetValue > st.batch
			##1 isBatch && batchSetValue != `TBDC_ZERO && batchSetValue <= st.batch && !pinBus.resetLvlB;
	endsequence
	sequence s_batchRstHeld;
		(isBatch && running && pinBus.resetLvlB) [*2];
	endsequence

	chk_total_clear: assert property (isTotal && running && pinBus.resetLvlB |=> st.total == `TBDC_ZERO)
		else $error("Total not cleared");
	chk_total_keeps: assert property (isTotal && running && pinBus.resetLvlA && pinBus.countPulseA &&
		!pinBus.resetLvlB && !pinBus.keyPulse && st.total != `TBDC_FULL_SCALE |=>
		st.total == $past(st.total) + `TBDC_ONE && st.present == `TBDC_ZERO) else $error("Total stopped under reset");
	chk_total_key: assert property (isTotal && running && pinBus.keyPulse && viewSel == tbdc_pkg::VIEW_TOTAL
		|=> st.total == `TBDC_ZERO && st.present == `TBDC_ZERO) else $error("Key left total or present");
	chk_total_wrap: assert property (isTotal && running && pinBus.countPulseA && !pinBus.resetLvlB &&
		st.total == `TBDC_FULL_SCALE |=> st.total == `TBDC_ZERO) else $error("Total did not wrap");
	chk_present_wrap: assert property (!isDual && running && pinBus.countPulseA && !pinBus.resetLvlA &&
		!pinBus.keyPulse && st.present == `TBDC_FULL_SCALE |=> st.present == `TBDC_ZERO) else $error("Present no wrap");
	chk_batch_held: assert property (s_batchRstHeld |=> st.batch == `TBDC_ZERO && !st.batchOut)
		else $error("Batch not held at zero");
	chk_batch_key: assert property (isBatch && running && pinBus.keyPulse && viewSel == tbdc_pkg::VIEW_BATCH
		|=> st.batch == `TBDC_ZERO && !st.batchOut && st.present == `TBDC_ZERO) else $error("Key left batch state");
	chk_batch_noout: assert property (running && batchSetValue == `TBDC_ZERO && !st.batchOut |=> !st.batchOut)
		else $error("Batch output with zero set value");
	chk_batch_sticky: assert property (isBatch && running && st.batchOut && !pinBus.resetLvlB &&
		!pinBus.keyPulse |=> st.batchOut) else $error("Batch output dropped");
	chk_batch_lower: assert property (s_setLowered |=> st.batchOut) else $error("Lowered set value missed");
	chk_batch_wrap: assert property (isBatch && running && complete && st.batch == `TBDC_FULL_SCALE &&
		!pinBus.resetLvlB && !pinBus.keyPulse |=> st.batch == `TBDC_ZERO) else $error("Batch did not wrap");
	chk_batch_step: assert property (isBatch && running && complete && st.batch != `TBDC_FULL_SCALE &&
		!pinBus.resetLvlB && !pinBus.keyPulse |=> st.batch == $past(st.batch) + `TBDC_ONE) else $error("Batch missed");
	chk_restore: assert property (st.phase == tbdc_pkg::PH_RESTORE |=> st.batchOut == $past(restoredBatchOut))
		else $error("Batch output not restored");
	chk_dual_rst: assert property (isDual && running && pinBus.resetLvlA |=> st.chanA == `TBDC_ZERO)
		else $error("Channel A not cleared");
	chk_dual_key: assert property (isDual && running && pinBus.keyPulse |=> st.chanA == `TBDC_ZERO &&
		st.chanB == `TBDC_ZERO && !st.ctrl) else $error("Key left dual state");
	chk_dual_stop: assert property (isDual && running && st.overflow && !pinBus.keyPulse && !pinBus.resetLvlA &&
		!pinBus.resetLvlB |=> $stable(st.chanA) && $stable(st.chanB)) else $error("Counting after overflow");
	chk_dual_match: assert property (isDual && running && dualBus.match && !pinBus.keyPulse |=> st.ctrl)
		else $error("Match gave no output");

	// The key level, not its edge, is what freezes the channels
	sequence s_keyHeld;
		isDual && running && pinBus.keyLvl && !pinBus.keyPulse && !pinBus.resetLvlA && !pinBus.resetLvlB;
	endsequence

	chk_dual_rstb: assert property (isDual && running && pinBus.resetLvlB |=> st.chanB == `TBDC_ZERO)
		else $error("Channel B not cleared");
	chk_chan_isolate: assert property (isDual && running && pinBus.resetLvlA && !pinBus.resetLvlB &&
		!pinBus.keyLvl && !st.overflow && pinBus.countPulseB && st.chanB != `TBDC_FULL_SCALE |=>
		st.chanB == $past(st.chanB) + `TBDC_ONE) else $error("Channel B disturbed by reset A");
	chk_key_freeze: assert property (s_keyHeld |=> $stable(st.chanA) && $stable(st.chanB))
		else $error("Counting while key held");
	chk_ovf_set: assert property (isDual && running && (ovA || ovB) |=> st.overflow)
		else $error("Overflow not flagged");
	chk_ovf_hold: assert property (isDual && running && st.overflow && !pinBus.keyPulse
		|=> st.overflow) else $error("Overflow dropped");
	chk_ctrl_hold: assert property (isDual && running && outputHold && st.ctrl && !pinBus.keyPulse
		|=> st.ctrl) else $error("Held control output dropped");
	chk_ctrl_follow: assert property (isDual && running && !outputHold && !dualBus.match |=> !st.ctrl)
		else $error("Control output without match");
	chk_present_rst: assert property (!isDual && running && pinBus.resetLvlA
		|=> st.present == `TBDC_ZERO && !st.ctrl) else $error("Present not cleared");
	chk_present_step: assert property (!isDual && running && pinBus.countPulseA && !pinBus.resetLvlA &&
		!pinBus.keyPulse && !complete && st.present != `TBDC_FULL_SCALE |=>
		st.present == $past(st.present) + `TBDC_ONE) else $error("Present missed a count");
	chk_present_rec: assert property (isBatch && running && complete |=> st.present == `TBDC_ZERO)
		else $error("Present not recycled");
	chk_total_step: assert property (isTotal && running && pinBus.countPulseA && !pinBus.resetLvlB &&
		!pinBus.keyPulse && st.total != `TBDC_FULL_SCALE |=> st.total == $past(st.total) + `TBDC_ONE)
		else $error("Total missed a count");
	chk_out_map: assert property (isBatch && running |=> st.firstOut == st.batchOut)
		else $error("First output not batch output");
	chk_batch_clear: assert property (isBatch && running && pinBus.resetLvlB
		|=> st.batch == `TBDC_ZERO && !st.batchOut) else $error("Batch reset missed");
	chk_batch_setout: assert property (isBatch && running && batchSetValue != `TBDC_ZERO && !complete &&
		st.batch >= batchSetValue && !pinBus.resetLvlB && !pinBus.keyPulse |=> st.batchOut)
		else $error("Batch output not set");
	chk_restore_once: assert property (running |=> running)
		else $error("Restore phase reentered");
endmodule
`default_nettype wire

// ---- tb/tbdc_sensor_model.sv ----
// Model of the count sensors, reset switches and front key
`timescale 1ns/1ps
`default_nettype none
`include "tbdc_params.svh"
module tbdc_sensor_model (
	input wire logic clk,
	output logic countA,
	output logic countB,
	output logic resetA,
	output logic resetB,
	output logic key
);
	logic [`TBDC_PIN_N-1:0] pins = '0;
	assign countA = pins[`TBDC_PIN_CNT_A];
	assign countB = pins[`TBDC_PIN_CNT_B];
	assign resetA = pins[`TBDC_PIN_RST_A];
	assign resetB = pins[`TBDC_PIN_RST_B];
	assign key = pins[`TBDC_PIN_KEY];
	// Pins move only on the falling edge, away from the sampling edge
	task automatic setLevel(input int ch, input logic v);
		@(negedge clk);
		pins[ch] = v;
	endtask
	// Four cycles high and four low, above the minimum width of the conditioner
	task automatic pulse(input int ch, input int n);
		repeat (n) begin
			setLevel(ch, 1'b1);
			repeat (3) @(negedge clk);
			setLevel(ch, 1'b0);
			repeat (3) @(negedge clk);
		end
	endtask
endmodule
`default_nettype wire

// ---- tb/tbdc_counter_core_test.sv ----
// Self-checking bench of the total, batch and dual counting core
`timescale 1ns/1ps
`default_nettype none
`include "tbdc_params.svh"
module tbdc_counter_core_test;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	tbdc_pkg::tbdc_mode_t modeSel = tbdc_pkg::MODE_TOTAL;
	tbdc_pkg::tbdc_view_t viewSel = tbdc_pkg::VIEW_PRESENT;
	logic outputHold = 1'b0;
	logic calcSubtract = 1'b0;
	logic [`TBDC_CNT_W-1:0] presetValue = 20'h00003;
	logic [`TBDC_CNT_W-1:0] batchSetValue = 20'h00002;
	logic signed [`TBDC_DUAL_W-1:0] dualSetValue = 21'h000001;
	logic restoredBatchOut = 1'b0;
	logic cntA, cntB, rstA, rstB, key;
	logic [`TBDC_CNT_W-1:0] presentCount, totalCount, batchCount, chanCountA, chanCountB;
	logic signed [`TBDC_DUAL_W-1:0] dualCount;
	logic overflowFlag, batchOutStore, firstControlOutput, secondControlOutput;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	localparam int A = `TBDC_PIN_CNT_A;
	localparam int B = `TBDC_PIN_CNT_B;
	localparam int RA = `TBDC_PIN_RST_A;
	localparam int RB = `TBDC_PIN_RST_B;
	localparam int K = `TBDC_PIN_KEY;

	tbdc_sensor_model i_tbdc_sensor_model (.clk(clk), .countA(cntA), .countB(cntB), .resetA(rstA), .resetB(rstB),
		.key(key));
	tbdc_counter_core i_tbdc_counter_core (.clk(clk), .resetn(resetn), .countInputA(cntA), .countInputB(cntB),
		.resetInputA(rstA), .resetInputB(rstB), .resetKey(key), .modeSel(modeSel), .viewSel(viewSel),
		.outputHold(outputHold), .calcSubtract(calcSubtract), .presetValue(presetValue),
		.batchSetValue(batchSetValue), .dualSetValue(dualSetValue), .restoredBatchOut(restoredBatchOut),
		.presentCount(presentCount), .totalCount(totalCount), .batchCount(batchCount), .chanCountA(chanCountA),
		.chanCountB(chanCountB), .dualCount(dualCount), .overflowFlag(overflowFlag), .batchOutStore(batchOutStore),
		.firstControlOutput(firstControlOutput), .secondControlOutput(secondControlOutput));

	initial begin
		forever #20 clk = ~clk;
	end

	task automatic stop_test;
		if (mismatches == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Hang guard; the whole sequence needs well under half of this
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches = mismatches + 1;
			stop_test();
		end
	end

	task automatic chkVal(input string name, input logic [`TBDC_DUAL_W-1:0] exp, input logic [`TBDC_DUAL_W-1:0] got);
		checked = checked + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chkBit(input string name, input logic exp, input logic got);
		checked = checked + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("wrong value %s expected %b seen %b", name, exp, got);
		end
	endtask

	// Count path is five edges deep plus the dual stage; ten cycles covers it
	task automatic settle;
		repeat (10) @(negedge clk);
	endtask

	task automatic pressLevel(input int ch);
		i_tbdc_sensor_model.setLevel(ch, 1'b1);
		repeat (5) @(negedge clk);
		i_tbdc_sensor_model.setLevel(ch, 1'b0);
		settle();
	endtask

	initial begin
		repeat (8) @(negedge clk);
		resetn = 1'b1;
		repeat (3) @(negedge clk);
		i_tbdc_sensor_model.pulse(A, 5);
		settle();
		chkVal("present", 21'h000005, {1'b0, presentCount});
		chkVal("total", 21'h000005, {1'b0, totalCount});
		pressLevel(RA);
		chkVal("present", 21'h000000, {1'b0, presentCount});
		chkVal("total", 21'h000005, {1'b0, totalCount});
		i_tbdc_sensor_model.pulse(A, 2);
		pressLevel(RB);
		chkVal("total", 21'h000000, {1'b0, totalCount});
		chkVal("present", 21'h000002, {1'b0, presentCount});
		i_tbdc_sensor_model.pulse(A, 1);
		viewSel = tbdc_pkg::VIEW_TOTAL;
		pressLevel(K);
		chkVal("total", 21'h000000, {1'b0, totalCount});
		chkVal("present", 21'h000000, {1'b0, presentCount});
		modeSel = tbdc_pkg::MODE_BATCH;
		viewSel = tbdc_pkg::VIEW_PRESENT;
		presetValue = 20'h00002;
		i_tbdc_sensor_model.pulse(A, 4);
		settle();
		chkVal("batch", 21'h000002, {1'b0, batchCount});
		chkVal("present", 21'h000000, {1'b0, presentCount});
		chkBit("batchOut", 1'b1, firstControlOutput);
		batchSetValue = 20'h00005;
		settle();
		chkBit("batchOut", 1'b1, firstControlOutput);
		// Completions while the batch reset is held must not show up
		i_tbdc_sensor_model.setLevel(RB, 1'b1);
		i_tbdc_sensor_model.pulse(A, 2);
		settle();
		chkVal("batch", 21'h000000, {1'b0, batchCount});
		chkBit("batchOut", 1'b0, firstControlOutput);
		chkBit("batchStore", 1'b0, batchOutStore);
		i_tbdc_sensor_model.setLevel(RB, 1'b0);
		i_tbdc_sensor_model.pulse(A, 4);
		batchSetValue = 20'h00000;
		i_tbdc_sensor_model.pulse(A, 2);
		settle();
		chkVal("batch", 21'h000003, {1'b0, batchCount});
		chkBit("batchOut", 1'b0, firstControlOutput);
		// Set value first above the batch count, then lowered below it
		batchSetValue = 20'h00005;
		settle();
		chkBit("batchOut", 1'b0, firstControlOutput);
		batchSetValue = 20'h00001;
		settle();
		chkBit("batchOut", 1'b1, firstControlOutput);
		i_tbdc_sensor_model.pulse(A, 1);
		viewSel = tbdc_pkg::VIEW_BATCH;
		pressLevel(K);
		chkVal("batch", 21'h000000, {1'b0, batchCount});
		chkVal("present", 21'h000000, {1'b0, presentCount});
		chkBit("batchOut", 1'b0, firstControlOutput);
		modeSel = tbdc_pkg::MODE_DUAL;
		viewSel = tbdc_pkg::VIEW_DUAL;
		pressLevel(K);
		chkVal("chanA", 21'h000000, {1'b0, chanCountA});
		i_tbdc_sensor_model.pulse(A, 3);
		i_tbdc_sensor_model.pulse(B, 2);
		settle();
		chkVal("dual", 21'h000005, dualCount);
		chkBit("control", 1'b0, secondControlOutput);
		calcSubtract = 1'b1;
		settle();
		chkVal("dual", 21'h000001, dualCount);
		chkBit("control", 1'b1, secondControlOutput);
		// A held control output must survive the loss of the match
		outputHold = 1'b1;
		i_tbdc_sensor_model.setLevel(RA, 1'b1);
		i_tbdc_sensor_model.pulse(A, 1);
		i_tbdc_sensor_model.pulse(B, 1);
		settle();
		chkVal("chanA", 21'h000000, {1'b0, chanCountA});
		chkVal("chanB", 21'h000003, {1'b0, chanCountB});
		chkVal("dual", 21'h1ffffd, dualCount);
		chkBit("control", 1'b1, secondControlOutput);
		i_tbdc_sensor_model.setLevel(RA, 1'b0);
		pressLevel(K);
		chkVal("chanB", 21'h000000, {1'b0, chanCountB});
		chkVal("dual", 21'h000000, dualCount);
		chkBit("control", 1'b0, secondControlOutput);
		chkBit("overflow", 1'b0, overflowFlag);
		// Power interruption with a saved batch output
		modeSel = tbdc_pkg::MODE_BATCH;
		batchSetValue = 20'h00005;
		restoredBatchOut = 1'b1;
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		repeat (3) @(negedge clk);
		chkBit("batchStore", 1'b1, batchOutStore);
		chkBit("batchOut", 1'b1, firstControlOutput);
		stop_test();
	end
endmodule
`default_nettype wire
